//--- logic/ifv_pkg.sv
// package: register map, field positions and shared types of the interrupt controller
package ifv_pkg;
  localparam int unsigned NSRC = 32; // register width, one bit per source
  localparam logic [31:0] OFF_NSTA = 32'hffff_0000;
  localparam logic [31:0] OFF_NSIG = 32'hffff_0004;
  localparam logic [31:0] OFF_NEN = 32'hffff_0008;
  localparam logic [31:0] OFF_NCLR = 32'hffff_000c;
  localparam logic [31:0] OFF_BASE = 32'hffff_0014;
  localparam logic [31:0] OFF_SWCFG = 32'hffff_0018; // chosen: no printed offset
  localparam logic [31:0] OFF_VEC = 32'hffff_001c;
  localparam logic [31:0] OFF_PRIO0 = 32'hffff_0020;
  localparam logic [31:0] OFF_NEST = 32'hffff_0030; // chosen: no printed offset
  localparam logic [31:0] OFF_FSTA = 32'hffff_0100;
  localparam logic [31:0] OFF_FSIG = 32'hffff_0104;
  localparam logic [31:0] OFF_FEN = 32'hffff_0108;
  localparam logic [31:0] OFF_FCLR = 32'hffff_010c;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam int unsigned NPRIO_REGS = 4; // priority registers, eight fields each
  localparam int unsigned SW_FAST_BIT = 2;
  localparam int unsigned SW_NORM_BIT = 1;
  localparam int unsigned SW_SRC_BIT = 1; // source bit driven by software
  localparam int unsigned FAST_OR_BIT = 0; // fast summary bit
  localparam int unsigned NEST_NORM_BIT = 0;
  localparam int unsigned NEST_FAST_BIT = 1;
  localparam int unsigned BASE_W = 16;
  localparam int unsigned VEC_BASE_LSB = 7;
  localparam int unsigned VEC_IDX_LSB = 2;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned PRIO_STRIDE = 4; // field plus reserved bit
  localparam int unsigned MAX_SRC = 27; // highest source index with a priority
  // one bus access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ifv_bus_type;
  // arbiter result
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [PRIO_W-1:0] prio;
  } ifv_win_type;
endpackage

//--- logic/ifv_arbiter.sv
// leaf: picks the highest priority pending source, lowest index on ties
module ifv_arbiter #(
  parameter int unsigned NSRC = 32
) (
  input wire logic [NSRC-1:0] pend,
  input wire logic [NSRC*ifv_pkg::PRIO_W-1:0] prio,
  output ifv_pkg::ifv_win_type win
);
  // scan from the top down so the lowest index wins a tie
  always_comb begin
    win = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i] && (!win.valid || prio[i*ifv_pkg::PRIO_W +: ifv_pkg::PRIO_W] >= win.prio)) begin // RL27 RL20
        win.valid = 1'b1;
        win.idx = ifv_pkg::IDX_W'(i);
        win.prio = prio[i*ifv_pkg::PRIO_W +: ifv_pkg::PRIO_W];
      end
    end
  end
endmodule // ifv_arbiter

//--- logic/ifv_ctrl.sv
// top: normal and fast interrupt paths with enable masks, software interrupts and vectoring
// Notes on behaviour
// RL1: normal enable bit gates source onto request
// RL2: writing zeros to enable clears nothing
// RL3: mask clear drops enable bits written one
// RL4: software clears masks only when not pending
// RL5: normal status is raw AND enable
// RL6: each normal status bit requests the core
// RL7: standard mode has no encoder or vector
// RL8: fast path mirrors the four normal registers
// RL9: fast bits 31:1 ORed into bit 0
// RL10: fast enable one clears normal enable bit
// RL11: normal enable one clears fast enable bit
// RL12: fast raw bits follow peripheral requests
// RL13: fast mask clear drops bits written one
// RL14: config bit 2 drives fast bit 1
// RL15: config bit 1 drives normal bit 1
// RL16: software interrupts bypass enable masks
// RL17: sources hold request past minimum latency
// RL18: nesting bits enable vectored normal/fast handling; here only bit 0 acts (normal vector index), bit 1 is only stored
// RL19: vectored mode nests eight levels per path; no nesting levels are kept here
// RL20: each source has programmable priority 0-7; here sources 28-31 have no field and stay at 0
// RL21: vector base holds 16 bits, upper zero
// RL22: vector points at active normal entry
// RL23: normal raw bits follow peripheral requests
// RL24: all normal status bits ORed to request
// RL25: vector packs base and winning index
// RL26: priority fields three bits, reserved between
// RL27: ties go to lowest source index
module ifv_ctrl #(
  parameter int unsigned NSRC = ifv_pkg::NSRC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] norm_src, // peripheral normal requests, level
  input wire logic [NSRC-1:0] fast_src, // peripheral fast requests, level
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic irq_out, // normal request to core
  output logic fiq_out // fast request to core
);
  ////////////////////////////////////////////////////////////////////////
  // state
  ifv_pkg::ifv_bus_type bus;
  logic [NSRC-1:0] norm_sig_reg; // sampled raw normal requests
  logic [NSRC-1:0] fast_sig_reg; // sampled raw fast requests
  logic [NSRC-1:0] norm_en_reg;
  logic [NSRC-1:0] fast_en_reg;
  logic [31:0] swcfg_reg;
  logic [1:0] nest_reg;
  logic [ifv_pkg::BASE_W-1:0] base_reg;
  logic [31:0] prio_reg [ifv_pkg::NPRIO_REGS];
  logic [NSRC-1:0] norm_sig_next; // raw view including software bit
  logic [NSRC-1:0] fast_sig_next;
  logic [NSRC-1:0] norm_sta;
  logic [NSRC-1:0] fast_sta;
  logic fast_any; // OR of fast status above bit 0
  logic [NSRC*ifv_pkg::PRIO_W-1:0] prio_flat;
  ifv_pkg::ifv_win_type win;
  logic [31:0] vec_val;
  logic [31:0] rdata_next;

  assign bus = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

  ////////////////////////////////////////////////////////////////////////
  // raw signal capture; inputs are synchronous so one stage is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      norm_sig_reg <= '0;
      fast_sig_reg <= '0;
    end else begin
      norm_sig_reg <= norm_src; // RL23
      fast_sig_reg <= fast_src; // RL12 RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // derived status; software bits overlay raw and status, unmasked
  always_comb begin
    norm_sig_next = norm_sig_reg;
    fast_sig_next = fast_sig_reg;
    norm_sig_next[ifv_pkg::SW_SRC_BIT] = swcfg_reg[ifv_pkg::SW_NORM_BIT]; // RL15
    fast_sig_next[ifv_pkg::SW_SRC_BIT] = swcfg_reg[ifv_pkg::SW_FAST_BIT]; // RL14
    fast_sta = fast_sig_next & fast_en_reg; // RL8
    fast_sta[ifv_pkg::SW_SRC_BIT] = swcfg_reg[ifv_pkg::SW_FAST_BIT]; // RL16
    fast_any = |fast_sta[NSRC-1:1]; // RL9
    fast_sta[ifv_pkg::FAST_OR_BIT] = fast_any; // RL9
    fast_sig_next[ifv_pkg::FAST_OR_BIT] = fast_any;
    norm_sig_next[ifv_pkg::FAST_OR_BIT] = fast_any;
    norm_sta = norm_sig_next & norm_en_reg; // RL1 RL5
    norm_sta[ifv_pkg::SW_SRC_BIT] = swcfg_reg[ifv_pkg::SW_NORM_BIT]; // RL16
  end

  ////////////////////////////////////////////////////////////////////////
  // enable masks: set by enable writes, cleared by clear writes or cross-path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      norm_en_reg <= '0;
      fast_en_reg <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        ifv_pkg::OFF_NEN: begin
          norm_en_reg <= norm_en_reg | bus.wdata[NSRC-1:0]; // RL2
          fast_en_reg <= fast_en_reg & ~bus.wdata[NSRC-1:0]; // RL11
        end
        ifv_pkg::OFF_FEN: begin
          fast_en_reg <= fast_en_reg | bus.wdata[NSRC-1:0]; // RL2
          norm_en_reg <= norm_en_reg & ~bus.wdata[NSRC-1:0]; // RL10
        end
        ifv_pkg::OFF_NCLR: norm_en_reg <= norm_en_reg & ~bus.wdata[NSRC-1:0]; // RL3
        ifv_pkg::OFF_FCLR: fast_en_reg <= fast_en_reg & ~bus.wdata[NSRC-1:0]; // RL13
        default: begin
          // other offsets leave masks alone
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers: software interrupt, nesting, base, priorities
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swcfg_reg <= ifv_pkg::RESET_VAL;
      nest_reg <= '0;
      base_reg <= '0;
      for (int i = 0; i < ifv_pkg::NPRIO_REGS; i++) begin
        prio_reg[i] <= ifv_pkg::RESET_VAL;
      end
    end else if (bus.wr) begin
      case (bus.addr)
        ifv_pkg::OFF_SWCFG: begin
          swcfg_reg <= '0;
          swcfg_reg[ifv_pkg::SW_FAST_BIT] <= bus.wdata[ifv_pkg::SW_FAST_BIT]; // RL14
          swcfg_reg[ifv_pkg::SW_NORM_BIT] <= bus.wdata[ifv_pkg::SW_NORM_BIT]; // RL15
        end
        ifv_pkg::OFF_NEST: nest_reg <= bus.wdata[1:0]; // RL18
        ifv_pkg::OFF_BASE: base_reg <= bus.wdata[ifv_pkg::BASE_W-1:0]; // RL21
        // base is also writable through the vector register field
        ifv_pkg::OFF_VEC: base_reg <= bus.wdata[ifv_pkg::VEC_BASE_LSB +: ifv_pkg::BASE_W];
        default: begin
          for (int i = 0; i < ifv_pkg::NPRIO_REGS; i++) begin
            if (bus.addr == ifv_pkg::OFF_PRIO0 + 32'(4 * i)) begin
              // reserved bits between fields kept at zero
              prio_reg[i] <= bus.wdata & 32'h7777_7777; // RL26
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority fields unpacked per source; source n lives at field n of the bank
  always_comb begin
    prio_flat = '0;
    for (int s = 0; s < NSRC; s++) begin
      if (s <= ifv_pkg::MAX_SRC) begin
        prio_flat[s*ifv_pkg::PRIO_W +: ifv_pkg::PRIO_W] =
          prio_reg[s / 8][(s % 8) * ifv_pkg::PRIO_STRIDE +: ifv_pkg::PRIO_W]; // RL20
      end
    end
  end

  // arbitrate normal status only; fast path sits above by the core's own order
  ifv_arbiter #(.NSRC(NSRC)) u_arb (
    .pend(norm_sta),
    .prio(prio_flat),
    .win(win)
  ); // RL19

  ////////////////////////////////////////////////////////////////////////
  // vector word; zero index when nothing active or vectoring is off
  always_comb begin
    vec_val = '0;
    vec_val[ifv_pkg::VEC_BASE_LSB +: ifv_pkg::BASE_W] = base_reg; // RL25
    if (nest_reg[ifv_pkg::NEST_NORM_BIT] && win.valid) begin // RL7 RL22
      vec_val[ifv_pkg::VEC_IDX_LSB +: ifv_pkg::IDX_W] = win.idx; // RL25
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_next = '0;
    case (bus.addr)
      ifv_pkg::OFF_NSTA: rdata_next = 32'(norm_sta); // RL5
      ifv_pkg::OFF_NSIG: rdata_next = 32'(norm_sig_next);
      ifv_pkg::OFF_NEN: rdata_next = 32'(norm_en_reg);
      ifv_pkg::OFF_FSTA: rdata_next = 32'(fast_sta);
      ifv_pkg::OFF_FSIG: rdata_next = 32'(fast_sig_next);
      ifv_pkg::OFF_FEN: rdata_next = 32'(fast_en_reg);
      ifv_pkg::OFF_SWCFG: rdata_next = swcfg_reg;
      ifv_pkg::OFF_NEST: rdata_next = {30'h0000_0000, nest_reg};
      ifv_pkg::OFF_BASE: rdata_next = {16'h0000, base_reg}; // RL21
      ifv_pkg::OFF_VEC: rdata_next = vec_val; // RL22
      default: begin
        for (int i = 0; i < ifv_pkg::NPRIO_REGS; i++) begin
          if (bus.addr == ifv_pkg::OFF_PRIO0 + 32'(4 * i)) begin
            rdata_next = prio_reg[i];
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs: read data one cycle after rd, requests to core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= '0;
    end else if (bus.rd) begin
      bus_rdata <= rdata_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
      fiq_out <= 1'b0;
    end else begin
      irq_out <= |norm_sta; // RL24 RL6
      fiq_out <= fast_any; // RL9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks: core requests follow the status words one cycle late
  // the request flops add one stage, so every check here looks one edge on
  a_irq_follows_sta: assert property (@(posedge clk) disable iff (rst) // RL24
    ##1 irq_out == (|$past(norm_sta)))
    else $error("irq request not OR of status");
  a_fiq_follows_or: assert property (@(posedge clk) disable iff (rst) // RL9
    ##1 fiq_out == (|$past(fast_sta[NSRC-1:1])))
    else $error("fiq request not OR of bits 31:1");
  // peripheral bits only: bits 0 and 1 are overlays and checked apart
  a_irq_enabled_src: assert property (@(posedge clk) disable iff (rst) // RL1 RL6
    (norm_sig_reg[NSRC-1:2] & norm_en_reg[NSRC-1:2]) != '0 |=> irq_out)
    else $error("enabled normal source gave no request");
  a_fiq_enabled_src: assert property (@(posedge clk) disable iff (rst) // RL8
    (fast_sig_reg[NSRC-1:2] & fast_en_reg[NSRC-1:2]) != '0 |=> fiq_out)
    else $error("enabled fast source gave no request");
  // software requests reach the core whatever the masks hold
  a_sw_unmasked: assert property (@(posedge clk) disable iff (rst) // RL16 RL15
    swcfg_reg[ifv_pkg::SW_NORM_BIT] |=> irq_out)
    else $error("sw irq masked");
  a_sw_fast_unmasked: assert property (@(posedge clk) disable iff (rst) // RL16 RL14
    swcfg_reg[ifv_pkg::SW_FAST_BIT] |=> fiq_out)
    else $error("sw fiq masked");

  ////////////////////////////////////////////////////////////////////////
  // checks: enable masks, set, clear and cross-path side effects
  // only one address per cycle, so a set and a clear of one bit never race
  a_en_exclusive: assert property (@(posedge clk) disable iff (rst) // RL10 RL11
    (norm_en_reg & fast_en_reg) == '0)
    else $error("source enabled on both paths");
  a_nen_sets_bit: assert property (@(posedge clk) disable iff (rst) // RL1
    bus.wr && bus.addr == ifv_pkg::OFF_NEN |=>
      (norm_en_reg & $past(bus.wdata[NSRC-1:0])) == $past(bus.wdata[NSRC-1:0]))
    else $error("normal enable write did not set");
  a_fen_sets_bit: assert property (@(posedge clk) disable iff (rst) // RL8
    bus.wr && bus.addr == ifv_pkg::OFF_FEN |=>
      (fast_en_reg & $past(bus.wdata[NSRC-1:0])) == $past(bus.wdata[NSRC-1:0]))
    else $error("fast enable write did not set");
  a_nen_clrs_fast: assert property (@(posedge clk) disable iff (rst) // RL11
    bus.wr && bus.addr == ifv_pkg::OFF_NEN |=> (fast_en_reg & $past(bus.wdata[NSRC-1:0])) == '0)
    else $error("normal enable left fast bit set");
  a_fen_clrs_norm: assert property (@(posedge clk) disable iff (rst) // RL10
    bus.wr && bus.addr == ifv_pkg::OFF_FEN |=> (norm_en_reg & $past(bus.wdata[NSRC-1:0])) == '0)
    else $error("fast enable left normal bit set");
  a_clr_drops_bit: assert property (@(posedge clk) disable iff (rst) // RL3
    bus.wr && bus.addr == ifv_pkg::OFF_NCLR |=> (norm_en_reg & $past(bus.wdata[NSRC-1:0])) == '0)
    else $error("normal clear left bit set");
  a_nclr_keeps_rest: assert property (@(posedge clk) disable iff (rst) // RL3
    bus.wr && bus.addr == ifv_pkg::OFF_NCLR |=>
      norm_en_reg == ($past(norm_en_reg) & ~$past(bus.wdata[NSRC-1:0])))
    else $error("normal clear touched other bits");
  a_fclr_drops_bit: assert property (@(posedge clk) disable iff (rst) // RL13
    bus.wr && bus.addr == ifv_pkg::OFF_FCLR |=> (fast_en_reg & $past(bus.wdata[NSRC-1:0])) == '0)
    else $error("fast clear left bit set");
  a_fclr_keeps_rest: assert property (@(posedge clk) disable iff (rst) // RL13
    bus.wr && bus.addr == ifv_pkg::OFF_FCLR |=>
      fast_en_reg == ($past(fast_en_reg) & ~$past(bus.wdata[NSRC-1:0])))
    else $error("fast clear touched other bits");
  a_en_no_zero_clr: assert property (@(posedge clk) disable iff (rst) // RL2
    bus.wr && bus.addr == ifv_pkg::OFF_NEN |=> (norm_en_reg & $past(norm_en_reg)) == $past(norm_en_reg))
    else $error("enable write cleared a bit");
  // the masks only move on a bus write; a quiet cycle must leave them alone
  a_masks_hold: assert property (@(posedge clk) disable iff (rst) // RL2
    !bus.wr |=> norm_en_reg == $past(norm_en_reg) && fast_en_reg == $past(fast_en_reg))
    else $error("mask changed without a write");

  ////////////////////////////////////////////////////////////////////////
  // checks: raw capture and status words as the core reads them
  // a source held high through reset would trip the raw checks; none is expected
  a_raw_follow: assert property (@(posedge clk) disable iff (rst) // RL12
    ##1 fast_sig_reg == $past(fast_src))
    else $error("fast raw lost request");
  a_nraw_follow: assert property (@(posedge clk) disable iff (rst) // RL23
    ##1 norm_sig_reg == $past(norm_src))
    else $error("normal raw lost request");
  a_nsta_read: assert property (@(posedge clk) disable iff (rst) // RL5
    bus.rd && bus.addr == ifv_pkg::OFF_NSTA |=>
      bus_rdata[NSRC-1:2] == ($past(norm_sig_reg[NSRC-1:2]) & $past(norm_en_reg[NSRC-1:2])))
    else $error("normal status read not raw and mask");
  a_fsta_read: assert property (@(posedge clk) disable iff (rst) // RL8
    bus.rd && bus.addr == ifv_pkg::OFF_FSTA |=>
      bus_rdata[NSRC-1:2] == ($past(fast_sig_reg[NSRC-1:2]) & $past(fast_en_reg[NSRC-1:2])))
    else $error("fast status read not raw and mask");
  a_sw_nraw: assert property (@(posedge clk) disable iff (rst) // RL15
    bus.rd && bus.addr == ifv_pkg::OFF_NSIG |=>
      bus_rdata[ifv_pkg::SW_SRC_BIT] == $past(swcfg_reg[ifv_pkg::SW_NORM_BIT]))
    else $error("normal raw sw bit wrong");
  a_sw_fraw: assert property (@(posedge clk) disable iff (rst) // RL14
    bus.rd && bus.addr == ifv_pkg::OFF_FSIG |=>
      bus_rdata[ifv_pkg::SW_SRC_BIT] == $past(swcfg_reg[ifv_pkg::SW_FAST_BIT]))
    else $error("fast raw sw bit wrong");

  ////////////////////////////////////////////////////////////////////////
  // checks: vector, base and priority words
  // the arbiter order itself is left to the bench; here only its shape
  a_base_upper: assert property (@(posedge clk) disable iff (rst) // RL21
    bus.rd && bus.addr == ifv_pkg::OFF_BASE |=> bus_rdata[31:16] == 16'h0000)
    else $error("base upper bits nonzero");
  a_vec_layout: assert property (@(posedge clk) disable iff (rst) // RL25
    bus.rd && bus.addr == ifv_pkg::OFF_VEC |=>
      bus_rdata[31:23] == '0 && bus_rdata[1:0] == '0 && bus_rdata[22:7] == $past(base_reg))
    else $error("vector word fields misplaced");
  a_vec_std_zero: assert property (@(posedge clk) disable iff (rst) // RL7
    bus.rd && bus.addr == ifv_pkg::OFF_VEC && !nest_reg[ifv_pkg::NEST_NORM_BIT] |=>
      bus_rdata[6:2] == '0)
    else $error("index shown in standard mode");
  a_win_any: assert property (@(posedge clk) disable iff (rst) // RL22
    win.valid == (|norm_sta))
    else $error("winner flag not any status");
  a_win_pending: assert property (@(posedge clk) disable iff (rst) // RL22 RL27
    win.valid |-> norm_sta[win.idx])
    else $error("winner is not pending");
  // reserved bits between the fields must never hold a one
  a_prio_reserved: assert property (@(posedge clk) disable iff (rst) // RL26
    bus.rd && bus.addr == ifv_pkg::OFF_PRIO0 |=> (bus_rdata & 32'h8888_8888) == '0)
    else $error("priority reserved bit set");
endmodule // ifv_ctrl

//--- sim/ifv_src_model.sv
// far-side model: peripheral interrupt sources holding level requests
module ifv_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] want_norm, // level each peripheral wants to show
  input wire logic [31:0] want_fast,
  output logic [31:0] norm_src,
  output logic [31:0] fast_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] norm_reg; // peripheral flags, registered
  logic [31:0] fast_reg;
  ////////////////////////////////////////////////////////////
  // a flag stays up until its peripheral clears it, far past the latency
  // bits 0 and 1 have no peripheral behind them, so they stay low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      norm_reg <= 32'h0000_0000;
      fast_reg <= 32'h0000_0000;
    end else begin
      norm_reg <= want_norm & 32'hffff_fffc;
      fast_reg <= want_fast & 32'hffff_fffc;
    end
  end
  assign norm_src = norm_reg;
  assign fast_src = fast_reg;
endmodule // ifv_src_model

//--- sim/ifv_ctrl_tb.sv
// testbench: masks, status, software requests and vectoring of the controller
module ifv_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: a write, source levels, a read and the answer expected
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [7:0] ns;
    logic [7:0] fs;
    logic [11:0] ra;
    logic [31:0] ex;
    logic [1:0] io; // expected irq_out, fiq_out
  } ifv_row_type;
  logic clk;
  logic rst;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic irq_out;
  logic fiq_out;
  logic [31:0] want_norm;
  logic [31:0] want_fast;
  logic [31:0] norm_src;
  logic [31:0] fast_src;
  logic [31:0] rd_val;
  int n_mismatch = 0;
  int cmp_count = 0;
  // 0xffc is an unmapped place, used as a write that does nothing
  ifv_row_type rows [24] = '{
    '{12'h008, 32'h0000_000c, 8'h04, 8'h00, 12'h000, 32'h0000_0004, 2'b10},
    '{12'h008, 32'h0000_0000, 8'h04, 8'h00, 12'h008, 32'h0000_000c, 2'b10},
    '{12'h00c, 32'h0000_0008, 8'h04, 8'h00, 12'h008, 32'h0000_0004, 2'b10},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h00, 12'h000, 32'h0000_0004, 2'b10},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h00, 12'h004, 32'h0000_0014, 2'b10},
    '{12'h108, 32'h0000_0004, 8'h14, 8'h04, 12'h008, 32'h0000_0000, 2'b01},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h04, 12'h100, 32'h0000_0005, 2'b01},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h04, 12'h104, 32'h0000_0005, 2'b01},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h04, 12'h004, 32'h0000_0015, 2'b01},
    '{12'h008, 32'h0000_0004, 8'h14, 8'h04, 12'h108, 32'h0000_0000, 2'b10},
    '{12'h108, 32'h0000_0010, 8'h14, 8'h04, 12'h108, 32'h0000_0010, 2'b10},
    '{12'h10c, 32'h0000_0010, 8'h14, 8'h04, 12'h108, 32'h0000_0000, 2'b10},
    '{12'h018, 32'h0000_0002, 8'h14, 8'h04, 12'h000, 32'h0000_0006, 2'b10},
    '{12'h018, 32'h0000_0004, 8'h14, 8'h04, 12'h100, 32'h0000_0003, 2'b11},
    '{12'hffc, 32'h0000_0000, 8'h14, 8'h04, 12'h004, 32'h0000_0015, 2'b11},
    '{12'h018, 32'h0000_0000, 8'h14, 8'h04, 12'h104, 32'h0000_0004, 2'b10},
    '{12'h014, 32'hffff_1234, 8'h14, 8'h04, 12'h014, 32'h0000_1234, 2'b10},
    '{12'h030, 32'h0000_0001, 8'h0c, 8'h04, 12'h000, 32'h0000_0004, 2'b10},
    '{12'h008, 32'h0000_0008, 8'h0c, 8'h04, 12'h01c, 32'h0009_1a08, 2'b10},
    '{12'h020, 32'h0000_5000, 8'h0c, 8'h04, 12'h01c, 32'h0009_1a0c, 2'b10},
    '{12'hffc, 32'h0000_0001, 8'h0c, 8'h04, 12'hffc, 32'h0000_0000, 2'b10},
    '{12'h004, 32'hffff_ffff, 8'h0c, 8'h04, 12'h004, 32'h0000_000c, 2'b10},
    '{12'hffc, 32'h0000_0000, 8'h00, 8'h00, 12'h004, 32'h0000_0000, 2'b00},
    '{12'hffc, 32'h0000_0000, 8'h00, 8'h00, 12'h104, 32'h0000_0000, 2'b00}
  };
  // places read back after the mid-run reset, the write-only clear among them
  logic [11:0] rst_addr [8] = '{12'h008, 12'h108, 12'h014, 12'h020, 12'h030, 12'h01c, 12'h00c, 12'h000};
  ////////////////////////////////////////////////////////////
  ifv_ctrl ifv_ctrl_i (.clk(clk), .rst(rst), .norm_src(norm_src), .fast_src(fast_src), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .irq_out(irq_out),
    .fiq_out(fiq_out));
  ifv_src_model ifv_src_model_i (.clk(clk), .rst(rst), .want_norm(want_norm), .want_fast(want_fast),
    .norm_src(norm_src), .fast_src(fast_src));
  ////////////////////////////////////////////////////////////
  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one-cycle write strobe; the low word offset is enough for this map
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= 32'hffff_0000 | 32'(a);
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken once the answering edge has landed
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= 32'hffff_0000 | 32'(a);
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // guard against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    $display("[FAIL] %0t run did not finish", $time);
    complete_run();
  end
  ////////////////////////////////////////////////////////////
  // main sequence: table rows, then the mid-run reset
  initial begin
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 32'h0000_0000;
    bus_wdata = 32'h0000_0000;
    want_norm = 32'h0000_0000;
    want_fast = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      want_norm <= 32'(rows[i].ns);
      want_fast <= 32'(rows[i].fs);
      bus_write(rows[i].wa, rows[i].wd);
      bus_read(rows[i].ra, rd_val);
      check(rd_val, rows[i].ex, "row read");
      check(32'({irq_out, fiq_out}), 32'(rows[i].io), "core requests");
    end
    // standard mode with a source pending: index field stays zero, fast nesting bit only stored
    @(posedge clk);
    want_norm <= 32'h0000_0004;
    bus_write(12'h030, 32'h0000_0002);
    bus_read(12'h030, rd_val);
    check(rd_val, 32'h0000_0002, "nesting readback");
    bus_read(12'h01c, rd_val);
    check(rd_val, 32'h0009_1a00, "vector in standard mode");
    check(32'({irq_out, fiq_out}), 32'h0000_0002, "pending source request");
    // state is loaded (masks, base, nesting, priority): reset it in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(32'({irq_out, fiq_out}), 32'h0000_0000, "requests in reset");
    check(bus_rdata, 32'h0000_0000, "read data in reset");
    @(posedge clk);
    rst <= 1'b0;
    foreach (rst_addr[j]) begin
      bus_read(rst_addr[j], rd_val);
      check(rd_val, 32'h0000_0000, "value after reset");
    end
    complete_run();
  end
endmodule // ifv_ctrl_tb
